// [hw/fdcr_pkg.sv]
/*
 * Shared constants, types and helper functions for the floppy controller
 * host register bank: the four host registers plus one local config word.
 * Assumes a 10 MHz clock and a classic Wishbone master on the host side.
 */
package fdcr_pkg;

	// register byte addresses
	localparam logic [7:0] FDCR_CFG_OFS  = 8'h00;
	localparam logic [7:0] FDCR_DIAG_OFS = 8'h04;
	localparam logic [7:0] FDCR_DOR_OFS  = 8'h08;
	localparam logic [7:0] FDCR_TDR_OFS  = 8'h0c;
	localparam logic [7:0] FDCR_MSR_OFS  = 8'h10;

	// reset values
	localparam logic [7:0] FDCR_DOR_RST  = 8'h00;
	localparam logic [1:0] FDCR_TAPE_RST = 2'h0;
	localparam logic [4:0] FDCR_CFG_RST  = 5'h00;
	localparam logic [7:0] FDCR_MSR_IDLE = 8'h00;

	// output register fields
	localparam int FDCR_DOR_MOTOR_LSB = 4;
	localparam int FDCR_DOR_DMA_IRQ_PIN_ENABLE     = 3;
	localparam int FDCR_DOR_RESET     = 2;
	localparam int FDCR_DOR_DSEL_LSB  = 0;

	// tape / media register fields
	localparam int FDCR_TDR_ID_EXTRA = 7;
	localparam int FDCR_TDR_ID_HIGH  = 6;
	localparam int FDCR_TDR_VALID    = 5;
	localparam int FDCR_TDR_TAPE_LSB = 0;

	// main status fields
	localparam int FDCR_MSR_RQM    = 7;
	localparam int FDCR_MSR_DIO    = 6;
	localparam int FDCR_MSR_NONDMA = 5;
	localparam int FDCR_MSR_CIP    = 4;
	localparam int FDCR_MSR_BUSY   = 0;

	// local config word fields
	localparam int FDCR_CFG_SENSE = 0;
	localparam int FDCR_CFG_PPM   = 1;
	localparam int FDCR_CFG_PNF   = 2;
	localparam int FDCR_CFG_FOUR  = 4;

	// timing
	localparam int FDCR_CLK_NS        = 100;
	localparam int FDCR_MSR_READY_NS  = 2500;
	localparam int FDCR_MSR_READY_CYC = FDCR_MSR_READY_NS / FDCR_CLK_NS;
	localparam int FDCR_SWRST_MIN_NS  = 100;
	localparam int FDCR_SWRST_CYC     =
		(FDCR_SWRST_MIN_NS + FDCR_CLK_NS - 1) / FDCR_CLK_NS;

	typedef enum logic [1:0] {
		FDCR_MODE_DESKTOP,
		FDCR_MODE_DIAG,
		FDCR_MODE_LEGACY
	} fdcr_mode_type;

	typedef enum logic [2:0] {
		FDCR_MEDIA_525,
		FDCR_MEDIA_288M,
		FDCR_MEDIA_144M,
		FDCR_MEDIA_720K,
		FDCR_MEDIA_NONE
	} fdcr_media_type;

	// classic wishbone request
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} fdcr_wb_req_type;

	// disk and media pins seen by the block
	typedef struct packed {
		logic second_drive_installed;
		logic write_data;
		logic read_data;
		logic write_gate;
		logic media_sense_pin_1;
		logic media_sense_pin_0;
		logic parport_data_7;
		logic parport_data_5;
		logic media_valid_pin_0;
		logic media_valid_pin_1;
	} fdcr_disk_in_type;

	// events and levels from the command engine
	typedef struct packed {
		logic       byte_ready;
		logic       data_xfer;
		logic       dir_to_host;
		logic       non_dma;
		logic       irq;
		logic       cmd_first;
		logic       cmd_last;
		logic       no_result;
		logic       result_last;
		logic       seek_issued;
		logic       sense_first;
		logic [1:0] drive;
		logic       swrst_pulse;
		logic       dir_read;
	} fdcr_engine_type;

	// drive control outputs
	typedef struct packed {
		logic [3:0] motor_on;
		logic [3:0] drive_sel;
		logic       dma_irq_pin_enable;
		logic       ctrl_reset;
		logic [1:0] tape_drive;
	} fdcr_drive_out_type;

	function automatic logic [3:0] fdcr_onehot(input logic [1:0] idx);
		fdcr_onehot = 4'h1 << idx;
	endfunction

	function automatic fdcr_mode_type fdcr_mode_decode(input logic [1:0] strap);
		case (strap)
			2'h1:    fdcr_mode_decode = FDCR_MODE_DIAG;
			2'h2:    fdcr_mode_decode = FDCR_MODE_LEGACY;
			default: fdcr_mode_decode = FDCR_MODE_DESKTOP;
		endcase
	endfunction

endpackage

// [hw/fdcr_edge_latch.sv]
/*
 * Sticky edge catcher for one disk-interface signal.
 * Assumes the signal is synchronous to the clock and reset is already synced.
 */
module fdcr_edge_latch #(
	parameter bit RISE = 1'b1
) (
	// clock and reset
	input  wire logic clock_in,
	input  wire logic rst_n_in,
	// signal and clear
	input  wire logic sig_in,
	input  wire logic clear_in,
	// latched flag
	output logic      latched_out
);
	typedef struct packed {
		logic prev;
		logic flag;
	} fdcr_latch_type;

	fdcr_latch_type state_r;
	fdcr_latch_type state_nxt;
	logic           edge_seen;

	// a set in the clearing cycle wins, so no edge is lost
	always_comb begin
		edge_seen = RISE ? (sig_in & ~state_r.prev) : (~sig_in & state_r.prev);
		state_nxt.prev = sig_in;
		state_nxt.flag = edge_seen | (state_r.flag & ~clear_in);
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign latched_out = state_r.flag;
endmodule

// [hw/fdcr_regs.sv]
/*
 * Host register bank of the floppy controller: latched diagnostic status,
 * drive output control, tape assignment / media sense, main status, and a
 * local config word. Assumes a classic Wishbone master, a command engine
 * that reports its phases as events, and pins synchronous to clock_in.
 */
module fdcr_regs (
	// clock and reset
	input  wire logic                        clock_in,
	input  wire logic                        resetn_in,
	// mode strap, sampled after reset release
	input  wire logic [1:0]                  mode_strap_in,
	// wishbone slave
	input  fdcr_pkg::fdcr_wb_req_type        wb_req_in,
	output logic                             wb_ack_out,
	output logic [31:0]                      wb_dat_out,
	// disk pins and command engine
	input  fdcr_pkg::fdcr_disk_in_type       disk_in,
	input  fdcr_pkg::fdcr_engine_type        engine_in,
	// drive control and media
	output fdcr_pkg::fdcr_drive_out_type     drive_out,
	output fdcr_pkg::fdcr_media_type         media_kind_out,
	output fdcr_pkg::fdcr_mode_type          mode_out
);
	import fdcr_pkg::*;

	localparam int CNT_W = $clog2(FDCR_MSR_READY_CYC + 1);
	localparam logic [CNT_W-1:0] READY_CNT = CNT_W'(FDCR_MSR_READY_CYC);
	localparam logic [1:0] SWRST_CNT = 2'(FDCR_SWRST_CYC);

	// drives 2 and 3 exist only in four-drive mode; shared by motors and selects
	function automatic logic [3:0] drive_mask(input logic four);
		drive_mask = {{2{four}}, 2'h3};
	endfunction

	typedef struct packed {
		logic            strap_done;
		fdcr_mode_type   mode;
		logic            ack;
		logic [7:0]      rdata;
		logic [7:0]      drive_output_control;
		logic [1:0]      tape;
		logic [4:0]      cfg;
		logic [1:0]      swrst_cnt;
		logic [CNT_W-1:0] init_cnt;
		logic            request_for_master;
		logic            transfer_direction;
		logic            nondma;
		logic            cip;
		logic [3:0]      busy;
	} fdcr_state_type;

	fdcr_state_type state_r;
	fdcr_state_type state_nxt;

	// reset synchroniser
	logic rst_meta_r;
	logic rst_n_r;

	// latched diagnostic bits
	logic wdata_seen;
	logic rdata_seen;
	logic write_gate_out_seen;

	// decoded views
	logic       ctrl_reset;
	logic       four_drive;
	logic [3:0] dsel_hot;
	logic [3:0] dsel_act;
	logic [3:0] motor_act;
	logic       media_extra;
	logic       media_high;
	logic       media_valid_n;
	logic [7:0] diag_val;
	logic [7:0] dor_val;
	logic [7:0] tdr_val;
	logic [7:0] msr_val;
	logic       rqm_view;
	logic       init_done;
	logic       req;
	logic       wr_take;
	logic       wr_lane0;
	logic       diag_strap;

	// reset released through two flops, asserted at once
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// edge catchers; cleared by a digital input register read
	fdcr_edge_latch #(.RISE(1'b0)) u_wdata (
		.clock_in    (clock_in),
		.rst_n_in    (rst_n_r),
		.sig_in      (disk_in.write_data),
		.clear_in    (engine_in.dir_read),
		.latched_out (wdata_seen)
	);
	fdcr_edge_latch #(.RISE(1'b0)) u_rdata (
		.clock_in    (clock_in),
		.rst_n_in    (rst_n_r),
		.sig_in      (disk_in.read_data),
		.clear_in    (engine_in.dir_read),
		.latched_out (rdata_seen)
	);
	fdcr_edge_latch #(.RISE(1'b1)) u_write_gate_out (
		.clock_in    (clock_in),
		.rst_n_in    (rst_n_r),
		.sig_in      (disk_in.write_gate),
		.clear_in    (engine_in.dir_read),
		.latched_out (write_gate_out_seen)
	);

	// controller reset: output bit low, or stretched self-clearing pulse
	assign ctrl_reset = ~state_r.drive_output_control[FDCR_DOR_RESET]
		| (state_r.swrst_cnt != 2'h0);

	// drive selects and motors, upper two only in four-drive mode
	assign four_drive = state_r.cfg[FDCR_CFG_FOUR];
	assign dsel_hot   = fdcr_onehot(state_r.drive_output_control[FDCR_DOR_DSEL_LSB +: 2]);
	assign dsel_act   = ctrl_reset ? 4'h0 : (dsel_hot & drive_mask(four_drive));
	assign motor_act  = state_r.drive_output_control[FDCR_DOR_MOTOR_LSB +: 4]
		& drive_mask(four_drive);

	// media id pins, parallel port source when muxed and selected
	always_comb begin
		if (state_r.cfg[FDCR_CFG_PPM] && !state_r.cfg[FDCR_CFG_PNF]) begin
			media_extra = disk_in.parport_data_7;
			media_high  = disk_in.parport_data_5;
		end else begin
			media_extra = disk_in.media_sense_pin_1;
			media_high  = disk_in.media_sense_pin_0;
		end
	end

	// valid flag per accessed drive; 1 means no media information
	always_comb begin
		media_valid_n = 1'b1;
		if (state_r.cfg[FDCR_CFG_SENSE]) begin
			case (state_r.drive_output_control[FDCR_DOR_DSEL_LSB +: 2])
				2'h0:    media_valid_n = disk_in.media_valid_pin_0;
				2'h1:    media_valid_n = disk_in.media_valid_pin_1;
				default: media_valid_n = 1'b1;
			endcase
		end
	end

	// media kind as seen by the host
	always_comb begin
		if (media_valid_n) begin
			media_kind_out = FDCR_MEDIA_NONE;
		end else begin
			case ({media_extra, media_high})
				2'h0:    media_kind_out = FDCR_MEDIA_525;
				2'h1:    media_kind_out = FDCR_MEDIA_288M;
				2'h2:    media_kind_out = FDCR_MEDIA_144M;
				default: media_kind_out = FDCR_MEDIA_720K;
			endcase
		end
	end

	// diagnostic register, active-low drive view in legacy mode only
	always_comb begin
		diag_val = 8'h00;
		if (state_r.mode == FDCR_MODE_LEGACY) begin
			diag_val = {~disk_in.second_drive_installed, ~dsel_act[1], ~dsel_act[0],
				wdata_seen, rdata_seen, write_gate_out_seen, ~dsel_act[3], ~dsel_act[2]};
		end
	end

	// output register read; dma enable reserved in diagnostic mode
	always_comb begin
		dor_val = state_r.drive_output_control;
		if (state_r.mode == FDCR_MODE_DIAG) begin
			dor_val[FDCR_DOR_DMA_IRQ_PIN_ENABLE] = 1'b0;
		end
	end

	// tape register read; reserved bits read zero
	assign tdr_val = {media_extra, media_high, media_valid_n, 3'h0, state_r.tape};

	// main status: zero until initialised, rqm follows irq in non-dma
	assign init_done = (state_r.init_cnt == READY_CNT);
	assign rqm_view  = state_r.nondma ? engine_in.irq : state_r.request_for_master;
	always_comb begin
		msr_val = FDCR_MSR_IDLE;
		if (init_done && !ctrl_reset) begin
			msr_val[FDCR_MSR_RQM]         = rqm_view;
			msr_val[FDCR_MSR_DIO]         = state_r.transfer_direction;
			msr_val[FDCR_MSR_NONDMA]      = state_r.nondma;
			msr_val[FDCR_MSR_CIP]         = state_r.cip;
			msr_val[FDCR_MSR_BUSY +: 4]   = state_r.busy;
		end
	end

	// bus qualifiers; a write lands on the edge where ack is seen high
	assign req      = wb_req_in.cyc & wb_req_in.stb;
	assign wr_take  = req & wb_req_in.we & state_r.ack;
	assign wr_lane0 = wr_take & wb_req_in.sel[0];

	// next state
	always_comb begin
		state_nxt = state_r;

		// mode strap caught once, after the release
		if (!state_r.strap_done) begin
			state_nxt.strap_done = 1'b1;
			state_nxt.mode       = fdcr_mode_decode(mode_strap_in);
		end

		// one-cycle ack, dropped the cycle after
		state_nxt.ack = req & ~state_r.ack;
		if (req && !state_r.ack) begin
			case (wb_req_in.adr)
				FDCR_CFG_OFS:  state_nxt.rdata = {3'h0, state_r.cfg};
				FDCR_DIAG_OFS: state_nxt.rdata = diag_val;
				FDCR_DOR_OFS:  state_nxt.rdata = dor_val;
				FDCR_TDR_OFS:  state_nxt.rdata = tdr_val;
				FDCR_MSR_OFS:  state_nxt.rdata = msr_val;
				default:       state_nxt.rdata = 8'h00;
			endcase
		end

		// register writes, any time, low byte lane
		if (wr_lane0) begin
			case (wb_req_in.adr)
				FDCR_CFG_OFS: state_nxt.cfg  = wb_req_in.dat[4:0];
				FDCR_DOR_OFS: state_nxt.drive_output_control  = wb_req_in.dat[7:0];
				FDCR_TDR_OFS: state_nxt.tape = wb_req_in.dat[1:0];
				default:      state_nxt.cfg  = state_r.cfg;
			endcase
		end

		// self-clearing data-rate reset, stretched to the minimum width
		if (engine_in.swrst_pulse) begin
			state_nxt.swrst_cnt = SWRST_CNT;
		end else if (state_r.swrst_cnt != 2'h0) begin
			state_nxt.swrst_cnt = state_r.swrst_cnt - 2'h1;
		end

		// init delay restarts on every controller reset
		if (ctrl_reset) begin
			state_nxt.init_cnt = '0;
		end else if (!init_done) begin
			state_nxt.init_cnt = state_r.init_cnt + CNT_W'(1);
		end

		// phase flags: cleared by controller reset, ready when init ends
		if (ctrl_reset) begin
			state_nxt.request_for_master    = 1'b0;
			state_nxt.transfer_direction    = 1'b0;
			state_nxt.nondma = 1'b0;
			state_nxt.cip    = 1'b0;
			state_nxt.busy   = 4'h0;
		end else if (!init_done) begin
			state_nxt.request_for_master = (state_r.init_cnt == READY_CNT - CNT_W'(1));
			state_nxt.transfer_direction = 1'b0;
		end else begin
			// byte handshake; a new ready beats the clear
			if (engine_in.byte_ready) begin
				state_nxt.request_for_master = 1'b1;
			end else if (engine_in.data_xfer) begin
				state_nxt.request_for_master = 1'b0;
			end
			state_nxt.transfer_direction    = engine_in.dir_to_host;
			state_nxt.nondma = engine_in.non_dma;

			// command in progress; ending byte beats the first byte
			if (engine_in.result_last
				|| (engine_in.cmd_last && engine_in.no_result)) begin
				state_nxt.cip = 1'b0;
			end else if (engine_in.cmd_first) begin
				state_nxt.cip = 1'b1;
			end

			// per-drive busy; seek set wins over a sense clear
			state_nxt.busy = state_r.busy
				& ~(engine_in.sense_first ? fdcr_onehot(engine_in.drive) : 4'h0)
				| (engine_in.seek_issued ? fdcr_onehot(engine_in.drive) : 4'h0);
		end
	end

	// all state on the synchronised reset
	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r            <= '0;
			state_r.mode       <= FDCR_MODE_DESKTOP;
			state_r.drive_output_control        <= FDCR_DOR_RST;
			state_r.tape       <= FDCR_TAPE_RST;
			state_r.cfg        <= FDCR_CFG_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// bus outputs
	assign wb_ack_out = state_r.ack;
	assign wb_dat_out = {24'h000000, state_r.rdata};
	assign mode_out   = state_r.mode;

	// the mode is only caught after reset, so until then a diagnostic strap itself
	// keeps the dma and irq pins enabled; otherwise they would float in reset
	assign diag_strap = ~state_r.strap_done
		& (fdcr_mode_decode(mode_strap_in) == FDCR_MODE_DIAG);

	// drive control outputs; dma pins always on in diagnostic mode
	always_comb begin
		drive_out.motor_on           = motor_act;
		drive_out.drive_sel          = dsel_act;
		drive_out.ctrl_reset         = ctrl_reset;
		drive_out.tape_drive         = state_r.tape;
		if (state_r.mode == FDCR_MODE_DIAG || diag_strap) begin
			drive_out.dma_irq_pin_enable = 1'b1;
		end else begin
			drive_out.dma_irq_pin_enable = state_r.drive_output_control[FDCR_DOR_DMA_IRQ_PIN_ENABLE];
		end
	end
endmodule

// [dv/fdcr_regs_asserts.sv]
/*
 * Concurrent checks on the floppy register bank ports.
 * Assumes a bind into fdcr_regs; it sees only that module's ports.
 */
module fdcr_regs_asserts (
	// clock and reset
	input wire logic                         clock_in,
	input wire logic                         resetn_in,
	input wire logic [1:0]                   mode_strap_in,
	// bus, pins and engine
	input wire fdcr_pkg::fdcr_wb_req_type    wb_req_in,
	input wire logic                         wb_ack_out,
	input wire logic [31:0]                  wb_dat_out,
	input wire fdcr_pkg::fdcr_disk_in_type   disk_in,
	input wire fdcr_pkg::fdcr_engine_type    engine_in,
	input wire fdcr_pkg::fdcr_drive_out_type drive_out,
	input wire fdcr_pkg::fdcr_media_type     media_kind_out,
	input wire fdcr_pkg::fdcr_mode_type      mode_out
);
	import fdcr_pkg::*;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	logic [7:0] dor_r;
	logic [4:0] cfg_r;
	logic [1:0] tape_r;
	logic [4:0] gap_r;
	logic       wr;
	logic [3:0] mask;
	logic [1:0] id;
	logic       vld_n;

	// a write lands on the edge that samples ack
	assign wr = wb_req_in.cyc && wb_req_in.we && wb_ack_out && wb_req_in.sel[0];
	assign mask = cfg_r[FDCR_CFG_FOUR] ? 4'hf : 4'h3;
	assign id = cfg_r[FDCR_CFG_PPM] && !cfg_r[FDCR_CFG_PNF]
		? {disk_in.parport_data_7, disk_in.parport_data_5}
		: {disk_in.media_sense_pin_1, disk_in.media_sense_pin_0};
	assign vld_n = !cfg_r[FDCR_CFG_SENSE] || dor_r[1] ? 1'b1
		: dor_r[0] ? disk_in.media_valid_pin_1 : disk_in.media_valid_pin_0;

	// shadow of what the host wrote
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			dor_r <= 8'h00;
			cfg_r <= 5'h00;
			tape_r <= 2'h0;
		end else if (wr && wb_req_in.adr == FDCR_DOR_OFS)
			dor_r <= wb_req_in.dat[7:0];
		else if (wr && wb_req_in.adr == FDCR_CFG_OFS)
			cfg_r <= wb_req_in.dat[4:0];
		else if (wr && wb_req_in.adr == FDCR_TDR_OFS)
			tape_r <= wb_req_in.dat[1:0];
	end

	// cycles since the controller left reset, saturating
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in)
			gap_r <= 5'h00;
		else if (drive_out.ctrl_reset)
			gap_r <= 5'h00;
		else if (gap_r != 5'h1f)
			gap_r <= gap_r + 5'h01;
	end

	sequence taken;
		wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
	endsequence
	sequence taken_rd(logic [7:0] a);
		taken ##0 !wb_req_in.we && wb_req_in.adr == a;
	endsequence
	sequence early_msr;
		taken_rd(FDCR_MSR_OFS) ##0 gap_r < 5'(FDCR_MSR_READY_CYC);
	endsequence
	sequence legacy_diag;
		taken_rd(FDCR_DIAG_OFS) ##0 mode_out == FDCR_MODE_LEGACY;
	endsequence

	ack_pulse_a: assert property (taken |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack is not one pulse a cycle after the request");
	motor_out_a: assert property (drive_out.motor_on == (dor_r[7:4] & mask))
		else $error("motor outputs differ from written bits");
	drive_sel_a: assert property (drive_out.drive_sel ==
		(drive_out.ctrl_reset ? 4'h0 : (4'h1 << dor_r[1:0]) & mask))
		else $error("drive select decode wrong");
	hold_reset_a: assert property (!dor_r[2] |-> drive_out.ctrl_reset)
		else $error("controller left reset while reset bit low");
	self_clear_a: assert property (engine_in.swrst_pulse |=> drive_out.ctrl_reset
		##2 drive_out.ctrl_reset == !dor_r[2])
		else $error("rate register reset not self clearing");
	dma_pins_a: assert property (drive_out.dma_irq_pin_enable ==
		(mode_out == FDCR_MODE_DIAG || dor_r[3]
		|| (mode_out == FDCR_MODE_DESKTOP && mode_strap_in == 2'h1)))
		else $error("dma pin enable wrong");
	tape_out_a: assert property (drive_out.tape_drive == tape_r)
		else $error("tape drive output differs from written field");
	media_kind_a: assert property (media_kind_out ==
		(vld_n ? FDCR_MEDIA_NONE : fdcr_media_type'({1'b0, id})))
		else $error("media kind decode wrong");
	dor_read_a: assert property (taken_rd(FDCR_DOR_OFS) |=> wb_dat_out ==
		{24'h0, dor_r & (mode_out == FDCR_MODE_DIAG ? 8'hf7 : 8'hff)})
		else $error("output register read back wrong");
	tdr_read_a: assert property (taken_rd(FDCR_TDR_OFS) |=> wb_dat_out ==
		{24'h0, $past(id), $past(vld_n), 3'h0, tape_r})
		else $error("tape and media register read wrong");
	msr_init_a: assert property (early_msr |=> wb_dat_out == 32'h0)
		else $error("status not zero while initialising");
	diag_pins_a: assert property (legacy_diag |=>
		wb_dat_out[7:5] == ~$past({disk_in.second_drive_installed, drive_out.drive_sel[1:0]})
		&& wb_dat_out[1:0] == ~$past(drive_out.drive_sel[3:2]))
		else $error("diag drive bits not inverted pins");
endmodule

bind fdcr_regs fdcr_regs_asserts chk (
	.clock_in, .resetn_in, .mode_strap_in, .wb_req_in, .wb_ack_out, .wb_dat_out, .disk_in,
	.engine_in, .drive_out, .media_kind_out, .mode_out
);

// [dv/fdcr_host_model.sv]
/*
 * Host processor model: a classic Wishbone master for the register bank.
 * Assumes one request at a time on a clock shared with the slave.
 */
module fdcr_host_model (
	// clock
	input  wire logic                 clock_in,
	// slave answer
	input  wire logic                 ack_in,
	input  wire logic [31:0]          dat_in,
	// request
	output fdcr_pkg::fdcr_wb_req_type req_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import fdcr_pkg::*;

	initial req_out = '0;

	// one cycle; qualifiers scrambled once released so stale values never match
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
		output logic [31:0] rd);
		fdcr_wb_req_type rq;
		@(posedge clock_in);
		req_out <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
		do
			@(posedge clock_in);
		while (ack_in !== 1'b1);
		rd = dat_in;
		rq = ~req_out;
		rq.cyc = 1'b0;
		rq.stb = 1'b0;
		req_out <= rq;
		@(posedge clock_in);
	endtask

	// back-to-back writes; the low phase lasts a whole bus cycle
	task automatic soft_reset(input logic [7:0] drive_output_control);
		logic [31:0] unused;
		xfer(1'b1, FDCR_DOR_OFS, drive_output_control & 8'hfb, unused);
		xfer(1'b1, FDCR_DOR_OFS, drive_output_control | 8'h04, unused);
	endtask
endmodule

// [dv/fdcr_regs_tb.sv]
/*
 * Self-checking bench for the floppy register bank over all strap modes.
 * Assumes the host model drives the bus and the checker is bound in.
 */
module fdcr_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fdcr_pkg::*;
	logic               clock_in = 1'b0;
	logic               resetn_in = 1'b0;
	logic [1:0]         strap = 2'h0;
	fdcr_wb_req_type    req;
	logic               ack;
	logic [31:0]        rdat;
	fdcr_disk_in_type   disk = '0;
	fdcr_engine_type    eng = '0;
	fdcr_drive_out_type dout;
	fdcr_media_type     media;
	fdcr_mode_type      mode;
	int                 mismatches = 0;
	int                 n_checks = 0;
	logic [7:0]         drive_output_control, tape_assign_media_sense, e;
	logic [4:0]         cfg;
	logic [31:0]        v;
	logic [7:0]         dor_tbl [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
	logic [14:0]        ev_tbl [8] = '{15'h0200, 15'h2000, 15'h5000, 15'h1028,
		15'h1180, 15'h1018, 15'h1800, 15'h1c00};
	logic [7:0]         msr_tbl [8] = '{8'h90, 8'h10, 8'hd0, 8'hd4, 8'hc4, 8'hc0, 8'h60, 8'he0};

	always #50 clock_in = ~clock_in;

	fdcr_regs dut (
		.clock_in(clock_in), .resetn_in(resetn_in), .mode_strap_in(strap),
		.wb_req_in(req), .wb_ack_out(ack), .wb_dat_out(rdat), .disk_in(disk),
		.engine_in(eng), .drive_out(dout), .media_kind_out(media), .mode_out(mode)
	);
	fdcr_host_model host (.clock_in(clock_in), .ack_in(ack), .dat_in(rdat), .req_out(req));

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 8'h00, v);
		cmp(v, exp);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, v);
	endtask
	// poll allowance covers the bus round trip on top of the init time
	task automatic wait_ready();
		int n;
		n = 0;
		v = 32'h0;
		while (v !== 32'h80 && n < 9) begin
			host.xfer(1'b0, FDCR_MSR_OFS, 8'h00, v);
			n++;
		end
		cmp(v, 32'h80);
	endtask
	// pulses last one cycle, levels stay
	task automatic ev(input logic [14:0] p);
		@(posedge clock_in);
		eng <= fdcr_engine_type'(p);
		@(posedge clock_in);
		eng <= fdcr_engine_type'(p & 15'h1c8c);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic logic [11:0] exp_drv(logic [7:0] d, logic [4:0] c, logic [1:0] t,
		logic [1:0] m);
		logic [3:0] k;
		logic [3:0] s;
		k = c[FDCR_CFG_FOUR] ? 4'hf : 4'h3;
		s = d[2] ? (4'h1 << d[1:0]) & k : 4'h0;
		return {d[7:4] & k, s, m == 2'h1 || d[3], !d[2], t};
	endfunction
	function automatic logic [7:0] exp_tdr(logic [7:0] d, logic [4:0] c, logic [1:0] t,
		fdcr_disk_in_type p);
		logic [1:0] id;
		logic       nv;
		id = c[FDCR_CFG_PPM] && !c[FDCR_CFG_PNF] ? {p.parport_data_7, p.parport_data_5}
			: {p.media_sense_pin_1, p.media_sense_pin_0};
		nv = !c[FDCR_CFG_SENSE] || d[1] ? 1'b1 : d[0] ? p.media_valid_pin_1 : p.media_valid_pin_0;
		return {id, nv, 3'h0, t};
	endfunction

	// run length is under two thousand cycles; this leaves wide margin
	initial begin
		#2000000;
		mismatches++;
		end_of_test();
	end

	initial begin
		v = $urandom(90);
		for (int m = 0; m < 4; m++) begin
			resetn_in <= 1'b0;
			strap <= 2'(m);
			eng <= '0;
			repeat (8) @(posedge clock_in);
			cmp({31'h0, dout.dma_irq_pin_enable}, {31'h0, m == 1});
			resetn_in <= 1'b1;
			repeat (3) @(posedge clock_in);
			rd_chk(FDCR_DOR_OFS, 32'h0);
			rd_chk(FDCR_MSR_OFS, 32'h0);
			rd_chk(FDCR_TDR_OFS, {24'h0, exp_tdr(8'h00, 5'h00, 2'h0, disk)});
			wr_reg(8'h14, 8'hff);
			rd_chk(8'h14, 32'h0);
			wr_reg(FDCR_DOR_OFS, 8'h04);
			wait_ready();
			cmp(32'(mode), m == 3 ? 32'h0 : 32'(m));
			$display("mode %0d reset done", m);
			for (int i = 0; i < 10; i++) begin
				cfg = i < 4 ? 5'h10 : 5'($urandom) & 5'h17;
				drive_output_control = i < 4 ? dor_tbl[i] : 8'($urandom);
				tape_assign_media_sense = 8'($urandom);
				disk <= fdcr_disk_in_type'(10'($urandom));
				wr_reg(FDCR_CFG_OFS, {3'h0, cfg});
				wr_reg(FDCR_DOR_OFS, drive_output_control);
				wr_reg(FDCR_TDR_OFS, tape_assign_media_sense);
				e = exp_tdr(drive_output_control, cfg, tape_assign_media_sense[1:0], disk);
				rd_chk(FDCR_DOR_OFS, {24'h0, m == 1 ? drive_output_control & 8'hf7 : drive_output_control});
				rd_chk(FDCR_TDR_OFS, {24'h0, e});
				cmp(32'(media), e[5] ? 32'(FDCR_MEDIA_NONE) : {30'h0, e[7:6]});
				cmp(32'(dout), 32'(exp_drv(drive_output_control, cfg, tape_assign_media_sense[1:0], 2'(m))));
			end
			$display("mode %0d random done", m);
			host.soft_reset(8'h15);
			rd_chk(FDCR_DOR_OFS, 32'h15);
			rd_chk(FDCR_MSR_OFS, 32'h0);
			wait_ready();
			ev(15'h0002);
			rd_chk(FDCR_MSR_OFS, 32'h0);
			wait_ready();
			for (int j = 0; j < 8; j++) begin
				ev(ev_tbl[j]);
				rd_chk(FDCR_MSR_OFS, {24'h0, msr_tbl[j]});
				rd_chk(FDCR_MSR_OFS, {24'h0, msr_tbl[j]});
			end
			$display("mode %0d status done", m);
			disk <= '0;
			wr_reg(FDCR_CFG_OFS, 8'h00);
			wr_reg(FDCR_DOR_OFS, 8'h15);
			ev(15'h0001);
			rd_chk(FDCR_DIAG_OFS, m == 2 ? 32'ha3 : 32'h0);
			disk <= fdcr_disk_in_type'(10'h180);
			@(posedge clock_in);
			disk <= fdcr_disk_in_type'(10'h040);
			@(posedge clock_in);
			rd_chk(FDCR_DIAG_OFS, m == 2 ? 32'hbf : 32'h0);
			ev(15'h0001);
			rd_chk(FDCR_DIAG_OFS, m == 2 ? 32'ha3 : 32'h0);
			$display("mode %0d latch done", m);
		end
		end_of_test();
	end
endmodule
